// >>> ppl_top.sv
// Top level of the parallel I/O port block with all nine port groups
`timescale 1ns/1ps
module ppl_top (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Processor access
	input  wire logic [3:0]  acc_port,
	input  wire logic [1:0]  acc_kind,
	input  wire logic [1:0]  acc_be,
	input  wire logic        acc_wr,
	input  wire logic        acc_rd,
	input  wire logic        acc_rmw,
	input  wire ppl_pkg::ppl_rmw_t acc_op,
	input  wire logic [15:0] acc_wdata,
	output logic      [15:0] acc_rdata,
	output logic             acc_rvalid,
	// Input threshold selection
	input  wire logic [12:0] input_threshold_select,
	output logic      [12:0] pad_thresh_cmos,
	// Port 0
	input  wire logic [15:0] p0_in,
	output logic      [15:0] p0_out,
	output logic      [15:0] p0_oe_n,
	input  wire logic [15:0] p0_alt_en,
	input  wire logic [15:0] p0_alt_out,
	input  wire logic [15:0] p0_hw_en,
	input  wire logic [15:0] p0_hw_dir,
	output logic      [15:0] p0_alt_in,
	// Port 1
	input  wire logic [15:0] p1_in,
	output logic      [15:0] p1_out,
	output logic      [15:0] p1_oe_n,
	input  wire logic [15:0] p1_alt_en,
	input  wire logic [15:0] p1_alt_out,
	input  wire logic [15:0] p1_hw_en,
	input  wire logic [15:0] p1_hw_dir,
	output logic      [15:0] p1_alt_in,
	// Port 2
	input  wire logic [15:0] p2_in,
	output logic      [15:0] p2_out,
	output logic      [15:0] p2_oe_n,
	input  wire logic [15:0] p2_alt_en,
	input  wire logic [15:0] p2_alt_out,
	output logic      [15:0] p2_alt_in,
	// Port 3
	input  wire logic [15:0] p3_in,
	output logic      [15:0] p3_out,
	output logic      [15:0] p3_oe_n,
	input  wire logic [15:0] p3_alt_en,
	input  wire logic [15:0] p3_alt_out,
	output logic      [15:0] p3_alt_in,
	// Port 4 with segment address
	input  wire logic [7:0]  p4_in,
	output logic      [7:0]  p4_out,
	output logic      [7:0]  p4_oe_n,
	input  wire logic [7:0]  p4_alt_en,
	input  wire logic [7:0]  p4_alt_out,
	output logic      [7:0]  p4_alt_in,
	input  wire logic        seg_addr_en,
	input  wire logic [7:0]  seg_addr,
	// Port 5, input only
	input  wire logic [15:0] p5_in,
	output logic      [15:0] p5_alt_in,
	// Port 6
	input  wire logic [7:0]  p6_in,
	output logic      [7:0]  p6_out,
	output logic      [7:0]  p6_oe_n,
	input  wire logic [7:0]  p6_alt_en,
	input  wire logic [7:0]  p6_alt_out,
	output logic      [7:0]  p6_alt_in,
	// Port 7
	input  wire logic [7:0]  p7_in,
	output logic      [7:0]  p7_out,
	output logic      [7:0]  p7_oe_n,
	input  wire logic [7:0]  p7_alt_en,
	input  wire logic [7:0]  p7_alt_out,
	output logic      [7:0]  p7_alt_in,
	// Port 8
	input  wire logic [7:0]  p8_in,
	output logic      [7:0]  p8_out,
	output logic      [7:0]  p8_oe_n,
	input  wire logic [7:0]  p8_alt_en,
	input  wire logic [7:0]  p8_alt_out,
	output logic      [7:0]  p8_alt_in
);
	logic [15:0] mask16;
	logic [7:0]  mask8;
	logic [15:0] rd0;
	logic [15:0] rd1;
	logic [15:0] rd2;
	logic [15:0] rd3;
	logic [7:0]  rd4;
	logic [15:0] rd5;
	logic [7:0]  rd6;
	logic [7:0]  rd7;
	logic [7:0]  rd8;
	logic [15:0] rd_sel;
	logic [15:0] p5_out_nc;
	logic [15:0] p5_oe_nc;
	logic [8:0]  sel;

	// Byte enables give each byte half its own access
	assign mask16 = {{8{acc_be[1]}}, {8{acc_be[0]}}};
	assign mask8  = {8{acc_be[0]}};

	assign sel[0] = (acc_port == ppl_pkg::PORT_P0);
	assign sel[1] = (acc_port == ppl_pkg::PORT_P1);
	assign sel[2] = (acc_port == ppl_pkg::PORT_P2);
	assign sel[3] = (acc_port == ppl_pkg::PORT_P3);
	assign sel[4] = (acc_port == ppl_pkg::PORT_P4);
	assign sel[5] = (acc_port == ppl_pkg::PORT_P5);
	assign sel[6] = (acc_port == ppl_pkg::PORT_P6);
	assign sel[7] = (acc_port == ppl_pkg::PORT_P7);
	assign sel[8] = (acc_port == ppl_pkg::PORT_P8);

	// Ports 0 and 1: bus lines turn around under hardware control
	ppl_port #(.W(16), .IMPL(ppl_pkg::IMPL_ALL), .OUT_EN(1'b1), .OD_EN(1'b0),
		.AUTO(ppl_pkg::AUTO_NONE), .PWM(ppl_pkg::PWM_NONE)) u_p0 (
		.mclk(mclk), .rst(rst),
		.wr_en(acc_wr & sel[0]), .rmw_en(acc_rmw & sel[0]), .kind(acc_kind),
		.mask(mask16), .wdata(acc_wdata), .op(acc_op), .rd_val(rd0),
		.alt_en(p0_alt_en), .alt_out(p0_alt_out),
		.hw_en(p0_hw_en), .hw_dir(p0_hw_dir), .alt_in(p0_alt_in),
		.pin_in(p0_in), .pin_out(p0_out), .pin_oe_n(p0_oe_n)
	);

	ppl_port #(.W(16), .IMPL(ppl_pkg::IMPL_ALL), .OUT_EN(1'b1), .OD_EN(1'b0),
		.AUTO(ppl_pkg::AUTO_NONE), .PWM(ppl_pkg::PWM_NONE)) u_p1 (
		.mclk(mclk), .rst(rst),
		.wr_en(acc_wr & sel[1]), .rmw_en(acc_rmw & sel[1]), .kind(acc_kind),
		.mask(mask16), .wdata(acc_wdata), .op(acc_op), .rd_val(rd1),
		.alt_en(p1_alt_en), .alt_out(p1_alt_out),
		.hw_en(p1_hw_en), .hw_dir(p1_hw_dir), .alt_in(p1_alt_in),
		.pin_in(p1_in), .pin_out(p1_out), .pin_oe_n(p1_oe_n)
	);

	ppl_port #(.W(16), .IMPL(ppl_pkg::IMPL_ALL), .OUT_EN(1'b1), .OD_EN(1'b1),
		.AUTO(ppl_pkg::AUTO_NONE), .PWM(ppl_pkg::PWM_NONE)) u_p2 (
		.mclk(mclk), .rst(rst),
		.wr_en(acc_wr & sel[2]), .rmw_en(acc_rmw & sel[2]), .kind(acc_kind),
		.mask(mask16), .wdata(acc_wdata), .op(acc_op), .rd_val(rd2),
		.alt_en(p2_alt_en), .alt_out(p2_alt_out),
		.hw_en(16'h0000), .hw_dir(16'h0000), .alt_in(p2_alt_in),
		.pin_in(p2_in), .pin_out(p2_out), .pin_oe_n(p2_oe_n)
	);

	// Port 3: line 14 absent, top line drives on its own once enabled
	ppl_port #(.W(16), .IMPL(ppl_pkg::IMPL_P3), .OUT_EN(1'b1), .OD_EN(1'b1),
		.AUTO(ppl_pkg::AUTO_P3), .PWM(ppl_pkg::PWM_NONE)) u_p3 (
		.mclk(mclk), .rst(rst),
		.wr_en(acc_wr & sel[3]), .rmw_en(acc_rmw & sel[3]), .kind(acc_kind),
		.mask(mask16), .wdata(acc_wdata), .op(acc_op), .rd_val(rd3),
		.alt_en(p3_alt_en), .alt_out(p3_alt_out),
		.hw_en(16'h0000), .hw_dir(16'h0000), .alt_in(p3_alt_in),
		.pin_in(p3_in), .pin_out(p3_out), .pin_oe_n(p3_oe_n)
	);

	// Port 4: segment address takes over all eight lines
	ppl_port #(.W(8), .IMPL(ppl_pkg::IMPL_ALL), .OUT_EN(1'b1), .OD_EN(1'b1),
		.AUTO(ppl_pkg::AUTO_NONE), .PWM(ppl_pkg::PWM_NONE)) u_p4 (
		.mclk(mclk), .rst(rst),
		.wr_en(acc_wr & sel[4]), .rmw_en(acc_rmw & sel[4]), .kind(acc_kind),
		.mask(mask8), .wdata(acc_wdata[7:0]), .op(acc_op), .rd_val(rd4),
		.alt_en(p4_alt_en),
		.alt_out(seg_addr_en ? seg_addr : p4_alt_out),
		.hw_en({8{seg_addr_en}}), .hw_dir(8'hFF), .alt_in(p4_alt_in),
		.pin_in(p4_in), .pin_out(p4_out), .pin_oe_n(p4_oe_n)
	);

	// Port 5 has no driver; its pin outputs are left unused
	ppl_port #(.W(16), .IMPL(ppl_pkg::IMPL_ALL), .OUT_EN(1'b0), .OD_EN(1'b0),
		.AUTO(ppl_pkg::AUTO_NONE), .PWM(ppl_pkg::PWM_NONE)) u_p5 (
		.mclk(mclk), .rst(rst),
		.wr_en(acc_wr & sel[5]), .rmw_en(acc_rmw & sel[5]), .kind(acc_kind),
		.mask(mask16), .wdata(acc_wdata), .op(acc_op), .rd_val(rd5),
		.alt_en(16'h0000), .alt_out(16'h0000),
		.hw_en(16'h0000), .hw_dir(16'h0000), .alt_in(p5_alt_in),
		.pin_in(p5_in), .pin_out(p5_out_nc), .pin_oe_n(p5_oe_nc)
	);

	ppl_port #(.W(8), .IMPL(ppl_pkg::IMPL_ALL), .OUT_EN(1'b1), .OD_EN(1'b1),
		.AUTO(ppl_pkg::AUTO_NONE), .PWM(ppl_pkg::PWM_NONE)) u_p6 (
		.mclk(mclk), .rst(rst),
		.wr_en(acc_wr & sel[6]), .rmw_en(acc_rmw & sel[6]), .kind(acc_kind),
		.mask(mask8), .wdata(acc_wdata[7:0]), .op(acc_op), .rd_val(rd6),
		.alt_en(p6_alt_en), .alt_out(p6_alt_out),
		.hw_en(8'h00), .hw_dir(8'h00), .alt_in(p6_alt_in),
		.pin_in(p6_in), .pin_out(p6_out), .pin_oe_n(p6_oe_n)
	);

	// Port 7: low four lines carry pulse-width outputs, not ANDed
	ppl_port #(.W(8), .IMPL(ppl_pkg::IMPL_ALL), .OUT_EN(1'b1), .OD_EN(1'b1),
		.AUTO(ppl_pkg::AUTO_NONE), .PWM(ppl_pkg::PWM_P7)) u_p7 (
		.mclk(mclk), .rst(rst),
		.wr_en(acc_wr & sel[7]), .rmw_en(acc_rmw & sel[7]), .kind(acc_kind),
		.mask(mask8), .wdata(acc_wdata[7:0]), .op(acc_op), .rd_val(rd7),
		.alt_en(p7_alt_en), .alt_out(p7_alt_out),
		.hw_en(8'h00), .hw_dir(8'h00), .alt_in(p7_alt_in),
		.pin_in(p7_in), .pin_out(p7_out), .pin_oe_n(p7_oe_n)
	);

	ppl_port #(.W(8), .IMPL(ppl_pkg::IMPL_ALL), .OUT_EN(1'b1), .OD_EN(1'b1),
		.AUTO(ppl_pkg::AUTO_NONE), .PWM(ppl_pkg::PWM_NONE)) u_p8 (
		.mclk(mclk), .rst(rst),
		.wr_en(acc_wr & sel[8]), .rmw_en(acc_rmw & sel[8]), .kind(acc_kind),
		.mask(mask8), .wdata(acc_wdata[7:0]), .op(acc_op), .rd_val(rd8),
		.alt_en(p8_alt_en), .alt_out(p8_alt_out),
		.hw_en(8'h00), .hw_dir(8'h00), .alt_in(p8_alt_in),
		.pin_in(p8_in), .pin_out(p8_out), .pin_oe_n(p8_oe_n)
	);

	// Read mux; unknown ports read zero, disabled byte lanes read zero
	always_comb begin
		case (acc_port)
			ppl_pkg::PORT_P0: rd_sel = rd0;
			ppl_pkg::PORT_P1: rd_sel = rd1;
			ppl_pkg::PORT_P2: rd_sel = rd2;
			ppl_pkg::PORT_P3: rd_sel = rd3;
			ppl_pkg::PORT_P4: rd_sel = {8'h00, rd4};
			ppl_pkg::PORT_P5: rd_sel = rd5;
			ppl_pkg::PORT_P6: rd_sel = {8'h00, rd6};
			ppl_pkg::PORT_P7: rd_sel = {8'h00, rd7};
			ppl_pkg::PORT_P8: rd_sel = {8'h00, rd8};
			default:          rd_sel = 16'h0000;
		endcase
	end

	// Read data shows the value before any same-cycle modify
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			acc_rdata  <= ppl_pkg::RDATA_RST;
			acc_rvalid <= 1'b0;
		end else begin
			acc_rvalid <= acc_rd | acc_rmw;
			if (acc_rd | acc_rmw) begin
				acc_rdata <= rd_sel & mask16;
			end
		end
	end

	// Threshold bits go to the pads only; logic is unaffected by them
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pad_thresh_cmos <= ppl_pkg::THRESH_RST;
		end else begin
			pad_thresh_cmos <= input_threshold_select;
		end
	end
endmodule : ppl_top

// >>> ppl_pkg.sv
// Package and the per-port line slice of the parallel I/O port block
// Summary of operation
// - Ports zero and one split into low and high bytes, each written separately.
// - Port three has fifteen lines; line fourteen is not built.
// - Port five is sixteen input-only lines with no output driver.
// - Ports two, three, four, six, seven, eight select open-drain per line.
// - Every pin is sampled into the input latch each state time.
// - Input lines: write updates latch only, read returns sampled pin.
// - Read-modify-write on input lines modifies the pin value into the latch.
// - Direction one enables the driver; read then returns the output latch.
// - Read-modify-write on output lines modifies the latch, changing the pin.
// - Threshold select is one bit per byte; sixteen-line ports two, three, five take two.
// - Direction and driver mode work the same for either threshold.
// - Input lines stay high impedance and ignore alternate outputs, except hardware-driven and auto-driven ones.
// - Alternate output is ANDed with the latch, except pulse-width and hardware-driven outputs.
// - Reset clears every direction bit so all lines start as inputs.
// - Output line with alternate input feeds the latch value to that input.
// - External bus lines switch direction by hardware, overriding the direction bit.
// - Some alternate outputs needed after reset drive without direction programming.
// - Port four can drive segment address bits sixteen to twenty-three.
// - Lines without an active alternate function stay general purpose I/O.
package ppl_pkg;
	localparam logic [3:0]  PORT_P0 = 4'h0;
	localparam logic [3:0]  PORT_P1 = 4'h1;
	localparam logic [3:0]  PORT_P2 = 4'h2;
	localparam logic [3:0]  PORT_P3 = 4'h3;
	localparam logic [3:0]  PORT_P4 = 4'h4;
	localparam logic [3:0]  PORT_P5 = 4'h5;
	localparam logic [3:0]  PORT_P6 = 4'h6;
	localparam logic [3:0]  PORT_P7 = 4'h7;
	localparam logic [3:0]  PORT_P8 = 4'h8;
	localparam logic [1:0]  KIND_DATA = 2'h0;
	localparam logic [1:0]  KIND_DIR  = 2'h1;
	localparam logic [1:0]  KIND_OD   = 2'h2;
	localparam logic [15:0] LATCH_RST = 16'h0000;
	localparam logic [15:0] DIR_RST   = 16'h0000;
	localparam logic [15:0] OD_RST    = 16'h0000;
	localparam logic [15:0] IMPL_ALL  = 16'hFFFF;
	localparam logic [15:0] IMPL_P3   = 16'hBFFF;
	localparam logic [15:0] AUTO_NONE = 16'h0000;
	localparam logic [15:0] AUTO_P3   = 16'h8000;
	localparam logic [15:0] PWM_NONE  = 16'h0000;
	localparam logic [15:0] PWM_P7    = 16'h000F;
	localparam logic [12:0] THRESH_RST = 13'h0000;
	localparam logic [15:0] RDATA_RST  = 16'h0000;
	typedef enum logic [1:0] {
		PPL_RMW_AND = 2'b00,
		PPL_RMW_OR  = 2'b01,
		PPL_RMW_XOR = 2'b10,
		PPL_RMW_MOV = 2'b11
	} ppl_rmw_t;
endpackage : ppl_pkg

`timescale 1ns/1ps
module ppl_port #(
	parameter int            W      = 16,
	parameter logic [15:0]   IMPL   = 16'hFFFF,
	parameter bit            OUT_EN = 1'b1,
	parameter bit            OD_EN  = 1'b1,
	parameter logic [15:0]   AUTO   = 16'h0000,
	parameter logic [15:0]   PWM    = 16'h0000
) (
	// Clock and reset
	input  wire logic            mclk,
	input  wire logic            rst,
	// Processor side
	input  wire logic            wr_en,
	input  wire logic            rmw_en,
	input  wire logic [1:0]      kind,
	input  wire logic [W-1:0]    mask,
	input  wire logic [W-1:0]    wdata,
	input  wire ppl_pkg::ppl_rmw_t op,
	output logic      [W-1:0]    rd_val,
	// Alternate function side
	input  wire logic [W-1:0]    alt_en,
	input  wire logic [W-1:0]    alt_out,
	input  wire logic [W-1:0]    hw_en,
	input  wire logic [W-1:0]    hw_dir,
	output logic      [W-1:0]    alt_in,
	// Pins
	input  wire logic [W-1:0]    pin_in,
	output logic      [W-1:0]    pin_out,
	output logic      [W-1:0]    pin_oe_n
);
	localparam logic [W-1:0] IMPL_W = IMPL[W-1:0];
	localparam logic [W-1:0] AUTO_W = AUTO[W-1:0];
	localparam logic [W-1:0] PWM_W  = PWM[W-1:0];
	localparam logic [W-1:0] DIR_OK = OUT_EN ? IMPL_W : '0;
	localparam logic [W-1:0] OD_OK  = (OUT_EN && OD_EN) ? IMPL_W : '0;

	logic [W-1:0] latch_reg;
	logic [W-1:0] dir_reg;
	logic [W-1:0] od_reg;
	logic [W-1:0] samp_reg;
	logic [W-1:0] rmw_val;
	logic [W-1:0] dir_eff;
	logic [W-1:0] drive_val;
	logic [W-1:0] wmask;
	logic [W-1:0] data_rd;

	assign wmask = mask & IMPL_W;
	// Data read picks latch for output lines, pin sample for input lines
	assign data_rd = (dir_reg & latch_reg) | (~dir_reg & samp_reg);
	// Reads return the register chosen by kind; no target reads zero
	assign rd_val = (kind == ppl_pkg::KIND_DIR) ? dir_reg
		: (kind == ppl_pkg::KIND_OD) ? od_reg
		: (kind == ppl_pkg::KIND_DATA) ? data_rd : '0;

	always_comb begin
		case (op)
			ppl_pkg::PPL_RMW_AND: rmw_val = data_rd & wdata;
			ppl_pkg::PPL_RMW_OR:  rmw_val = data_rd | wdata;
			ppl_pkg::PPL_RMW_XOR: rmw_val = data_rd ^ wdata;
			default:              rmw_val = wdata;
		endcase
	end

	// Hardware override, then auto-driven lines, then the software bit
	assign dir_eff = ((hw_en & hw_dir) | (~hw_en & (dir_reg | (AUTO_W & alt_en))))
		& DIR_OK;
	assign drive_val = (hw_en & alt_out)
		| (~hw_en & alt_en & PWM_W & alt_out)
		| (~hw_en & alt_en & ~PWM_W & alt_out & latch_reg)
		| (~hw_en & ~alt_en & latch_reg);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			samp_reg <= '0;
		end else begin
			samp_reg <= pin_in & IMPL_W;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			latch_reg <= ppl_pkg::LATCH_RST[W-1:0];
		end else if (kind == ppl_pkg::KIND_DATA && rmw_en) begin
			latch_reg <= (latch_reg & ~wmask) | (rmw_val & wmask);
		end else if (kind == ppl_pkg::KIND_DATA && wr_en) begin
			latch_reg <= (latch_reg & ~wmask) | (wdata & wmask);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dir_reg <= ppl_pkg::DIR_RST[W-1:0];
		end else if (kind == ppl_pkg::KIND_DIR && wr_en) begin
			dir_reg <= (dir_reg & ~wmask) | (wdata & wmask & DIR_OK);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			od_reg <= ppl_pkg::OD_RST[W-1:0];
		end else if (kind == ppl_pkg::KIND_OD && wr_en) begin
			od_reg <= (od_reg & ~wmask) | (wdata & wmask & OD_OK);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_out  <= '0;
			pin_oe_n <= '1;
			alt_in   <= '0;
		end else begin
			pin_out  <= drive_val & ~od_reg;
			pin_oe_n <= ~(dir_eff & (~od_reg | ~drive_val));
			alt_in   <= ((dir_reg & ~hw_en & latch_reg)
				| (~(dir_reg & ~hw_en) & samp_reg)) & IMPL_W;
		end
	end
endmodule : ppl_port

// >>> ppl_top_monitor.sv
// Concurrent checks on the parallel I/O port block top level
`timescale 1ns/1ps
module ppl_top_monitor (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// Processor access
	input wire logic        acc_rd,
	input wire logic        acc_rmw,
	input wire logic [1:0]  acc_be,
	input wire logic        acc_rvalid,
	input wire logic [15:0] acc_rdata,
	// Thresholds
	input wire logic [12:0] input_threshold_select,
	input wire logic [12:0] pad_thresh_cmos,
	// Pins and alternate functions
	input wire logic [15:0] p0_hw_en,
	input wire logic [15:0] p0_hw_dir,
	input wire logic [15:0] p0_alt_out,
	input wire logic [15:0] p0_out,
	input wire logic [15:0] p0_oe_n,
	input wire logic [15:0] p2_alt_en,
	input wire logic [15:0] p2_alt_out,
	input wire logic [15:0] p2_out,
	input wire logic [15:0] p2_oe_n,
	input wire logic [15:0] p3_oe_n,
	input wire logic [7:0]  p4_out,
	input wire logic [7:0]  p4_oe_n,
	input wire logic        seg_addr_en,
	input wire logic [7:0]  seg_addr
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_rvalid_timing: assert property (!$past(rst) |-> acc_rvalid == $past(acc_rd || acc_rmw))
		else $error("read valid not one cycle after request");
	a_lane_off: assert property (acc_rd && !acc_be[1] |=> acc_rdata[15:8] == 8'h00)
		else $error("disabled high lane returned data");
	a_p3_gap: assert property (p3_oe_n[14])
		else $error("absent port three line is driven");
	a_thresh_copy: assert property (!$past(rst) |-> pad_thresh_cmos == $past(input_threshold_select))
		else $error("threshold output does not follow select");
	a_reset_float: assert property ($past(rst) |-> &{p0_oe_n, p2_oe_n, p3_oe_n, p4_oe_n})
		else $error("line driven right after reset");
	a_seg_drive: assert property (seg_addr_en |=> p4_oe_n == 8'h00 && p4_out == $past(seg_addr))
		else $error("segment address not on port four");
	a_hw_dir: assert property ((~p0_oe_n & $past(p0_hw_en)) == $past(p0_hw_en & p0_hw_dir))
		else $error("hardware direction not followed");
	a_hw_data: assert property (((p0_out ^ $past(p0_alt_out)) & $past(p0_hw_en & p0_hw_dir)) == 16'h0000)
		else $error("hardware driven line lost alternate data");
	a_alt_and: assert property ((p2_out & $past(p2_alt_en & ~p2_alt_out)) == 16'h0000)
		else $error("alternate zero not forced on pin");
endmodule : ppl_top_monitor

bind ppl_top ppl_top_monitor ppl_top_monitor_inst (.mclk, .rst, .acc_rd, .acc_rmw, .acc_be,
	.acc_rvalid, .acc_rdata, .input_threshold_select, .pad_thresh_cmos, .p0_hw_en, .p0_hw_dir,
	.p0_alt_out, .p0_out, .p0_oe_n, .p2_alt_en, .p2_alt_out, .p2_out, .p2_oe_n, .p3_oe_n,
	.p4_out, .p4_oe_n, .seg_addr_en, .seg_addr);

// >>> ppl_ext_pins.sv
// External devices on one port: a driver per line and a pull-up
`timescale 1ns/1ps
module ppl_ext_pins #(
	parameter int W = 16
) (
	// Block side
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe_n,
	// Stimulus
	input  wire logic [W-1:0] ext_val,
	input  wire logic [W-1:0] ext_drv,
	// Wire level
	output logic      [W-1:0] pin_lvl
);
	// Released and undriven lines float up to the pull-up
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : (ext_drv[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule : ppl_ext_pins

// >>> ppl_top_tb.sv
// Self-checking testbench for the parallel I/O port block
`timescale 1ns/1ps
module ppl_top_tb;
	logic mclk = 1'b0;
	logic rst, acc_wr, acc_rd, acc_rmw, acc_rvalid, seg_addr_en;
	logic [3:0] acc_port;
	logic [1:0] acc_kind, acc_be;
	ppl_pkg::ppl_rmw_t acc_op;
	logic [12:0] input_threshold_select, pad_thresh_cmos;
	logic [15:0] acc_wdata, acc_rdata, p5_in, p5_alt_in, xv [9], xd [9];
	logic [15:0] p0_in, p0_out, p0_oe_n, p0_alt_en, p0_alt_out, p0_hw_en, p0_hw_dir, p0_alt_in;
	logic [15:0] p1_in, p1_out, p1_oe_n, p1_alt_en, p1_alt_out, p1_hw_en, p1_hw_dir, p1_alt_in;
	logic [15:0] p2_in, p2_out, p2_oe_n, p2_alt_en, p2_alt_out, p2_alt_in;
	logic [15:0] p3_in, p3_out, p3_oe_n, p3_alt_en, p3_alt_out, p3_alt_in;
	logic [7:0]  p4_in, p4_out, p4_oe_n, p4_alt_en, p4_alt_out, p4_alt_in, seg_addr;
	logic [7:0]  p6_in, p6_out, p6_oe_n, p6_alt_en, p6_alt_out, p6_alt_in;
	logic [7:0]  p7_in, p7_out, p7_oe_n, p7_alt_en, p7_alt_out, p7_alt_in;
	logic [7:0]  p8_in, p8_out, p8_oe_n, p8_alt_en, p8_alt_out, p8_alt_in;
	int          n_errors;
	int          compares;

	ppl_top ppl_top_inst (.mclk, .rst, .acc_port, .acc_kind, .acc_be, .acc_wr, .acc_rd, .acc_rmw,
		.acc_op, .acc_wdata, .acc_rdata, .acc_rvalid, .input_threshold_select, .pad_thresh_cmos,
		.p0_in, .p0_out, .p0_oe_n, .p0_alt_en, .p0_alt_out, .p0_hw_en, .p0_hw_dir, .p0_alt_in,
		.p1_in, .p1_out, .p1_oe_n, .p1_alt_en, .p1_alt_out, .p1_hw_en, .p1_hw_dir, .p1_alt_in,
		.p2_in, .p2_out, .p2_oe_n, .p2_alt_en, .p2_alt_out, .p2_alt_in,
		.p3_in, .p3_out, .p3_oe_n, .p3_alt_en, .p3_alt_out, .p3_alt_in,
		.p4_in, .p4_out, .p4_oe_n, .p4_alt_en, .p4_alt_out, .p4_alt_in, .seg_addr_en, .seg_addr,
		.p5_in, .p5_alt_in, .p6_in, .p6_out, .p6_oe_n, .p6_alt_en, .p6_alt_out, .p6_alt_in,
		.p7_in, .p7_out, .p7_oe_n, .p7_alt_en, .p7_alt_out, .p7_alt_in,
		.p8_in, .p8_out, .p8_oe_n, .p8_alt_en, .p8_alt_out, .p8_alt_in);

	ppl_ext_pins #(16) x0 (.pin_out(p0_out), .pin_oe_n(p0_oe_n), .ext_val(xv[0]), .ext_drv(xd[0]),
		.pin_lvl(p0_in));
	ppl_ext_pins #(16) x1 (.pin_out(p1_out), .pin_oe_n(p1_oe_n), .ext_val(xv[1]), .ext_drv(xd[1]),
		.pin_lvl(p1_in));
	ppl_ext_pins #(16) x2 (.pin_out(p2_out), .pin_oe_n(p2_oe_n), .ext_val(xv[2]), .ext_drv(xd[2]),
		.pin_lvl(p2_in));
	ppl_ext_pins #(16) x3 (.pin_out(p3_out), .pin_oe_n(p3_oe_n), .ext_val(xv[3]), .ext_drv(xd[3]),
		.pin_lvl(p3_in));
	ppl_ext_pins #(8) x4 (.pin_out(p4_out), .pin_oe_n(p4_oe_n), .ext_val(xv[4][7:0]),
		.ext_drv(xd[4][7:0]), .pin_lvl(p4_in));
	ppl_ext_pins #(8) x6 (.pin_out(p6_out), .pin_oe_n(p6_oe_n), .ext_val(xv[6][7:0]),
		.ext_drv(xd[6][7:0]), .pin_lvl(p6_in));
	ppl_ext_pins #(8) x7 (.pin_out(p7_out), .pin_oe_n(p7_oe_n), .ext_val(xv[7][7:0]),
		.ext_drv(xd[7][7:0]), .pin_lvl(p7_in));
	ppl_ext_pins #(8) x8 (.pin_out(p8_out), .pin_oe_n(p8_oe_n), .ext_val(xv[8][7:0]),
		.ext_drv(xd[8][7:0]), .pin_lvl(p8_in));

	always #12.5 mclk = ~mclk;

	task automatic step();
		@(posedge mclk);
		#1;
	endtask : step

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One access pulse; t is {rmw, rd, wr}
	task automatic acc(input logic [3:0] p, input logic [1:0] k, input logic [1:0] be,
		input logic [2:0] t, input logic [15:0] d, input ppl_pkg::ppl_rmw_t o = ppl_pkg::PPL_RMW_MOV);
		{acc_port, acc_kind, acc_be, acc_wdata} = {p, k, be, d};
		acc_op = o;
		{acc_rmw, acc_rd, acc_wr} = t;
		step();
		{acc_rmw, acc_rd, acc_wr} = 3'h0;
		step();
	endtask : acc

	// Read data and valid stand for the cycle after the taking edge
	task automatic rd(input logic [3:0] p, input logic [1:0] k, input logic [15:0] e,
		input string nm, input logic [1:0] be = 2'h3);
		{acc_port, acc_kind, acc_be, acc_wdata} = {p, k, be, 16'h0000};
		acc_rd = 1'b1;
		step();
		acc_rd = 1'b0;
		chk(nm, 16'h0001, {15'h0000, acc_rvalid});
		chk(nm, e, acc_rdata);
		step();
	endtask : rd

	task automatic t_io();
		rd(4'h2, 2'h1, 16'h0000, "p2 dir reset");
		{xd[2], xv[2]} = {16'hFFFF, 16'hA5C3};
		acc(4'h2, 2'h0, 2'h3, 3'h1, 16'h1234);
		step();
		chk("p2 oe_n input", 16'hFFFF, p2_oe_n);
		rd(4'h2, 2'h0, 16'hA5C3, "p2 pin read");
		acc(4'h2, 2'h0, 2'h3, 3'h4, 16'h000F, ppl_pkg::PPL_RMW_OR);
		xd[2] = 16'h0000;
		acc(4'h2, 2'h1, 2'h3, 3'h1, 16'hFFFF);
		rd(4'h2, 2'h0, 16'hA5CF, "p2 latch read");
		chk("p2 out", 16'hA5CF, p2_out);
		acc(4'h2, 2'h0, 2'h3, 3'h4, 16'hFF00, ppl_pkg::PPL_RMW_XOR);
		step();
		chk("p2 out rmw", 16'h5ACF, p2_out);
		acc(4'h2, 2'h2, 2'h3, 3'h1, 16'hFFFF);
		step();
		chk("p2 oe_n od", 16'h5ACF, p2_oe_n);
		chk("p2 out od", 16'h0000, p2_out);
		chk("p2 wire od", 16'h5ACF, p2_in);
		acc(4'h2, 2'h2, 2'h3, 3'h1, 16'h0000);
		acc(4'h2, 2'h0, 2'h3, 3'h1, 16'hFFFF);
		p2_alt_out = 16'h1234;
		p2_alt_en = 16'hFFFF;
		step();
		step();
		chk("p2 alt out", 16'h1234, p2_out);
		acc(4'h2, 2'h0, 2'h3, 3'h1, 16'h00FF);
		step();
		chk("p2 alt and", 16'h0034, p2_out);
		p2_alt_en = 16'h0000;
		step();
		step();
		chk("p2 gpio out", 16'h00FF, p2_out);
		chk("p2 alt in", 16'h00FF, p2_alt_in);
		acc(4'h2, 2'h1, 2'h3, 3'h1, 16'h0000);
		p2_alt_en = 16'hFFFF;
		step();
		step();
		chk("p2 alt ignored", 16'hFFFF, p2_oe_n);
		p2_alt_en = 16'h0000;
		$display("t_io done");
	endtask : t_io

	task automatic t_p0();
		{xd[0], xv[0]} = {16'h00FF, 16'h5A5A};
		acc(4'h0, 2'h0, 2'h1, 3'h1, 16'hABCD);
		acc(4'h0, 2'h1, 2'h2, 3'h1, 16'hFFFF);
		step();
		chk("p0 oe_n lanes", 16'h00FF, p0_oe_n);
		rd(4'h0, 2'h0, 16'h005A, "p0 lanes");
		acc(4'h0, 2'h0, 2'h2, 3'h1, 16'hABCD);
		rd(4'h0, 2'h0, 16'h005A, "p0 high lane off", 2'h1);
		{p0_hw_en, p0_hw_dir, p0_alt_out} = {16'hFFFF, 16'h00FF, 16'h3C3C};
		step();
		step();
		chk("p0 hw oe_n", 16'hFF00, p0_oe_n);
		chk("p0 hw out", 16'h003C, {8'h00, p0_out[7:0]});
		p0_hw_en = 16'h0000;
		$display("t_p0 done");
	endtask : t_p0

	task automatic t_misc();
		{p3_alt_en, p3_alt_out} = {16'h8000, 16'h0000};
		step();
		step();
		chk("p3 auto line", 16'h0000, {15'h0000, p3_oe_n[15]});
		p3_alt_en = 16'h0000;
		acc(4'h3, 2'h1, 2'h3, 3'h1, 16'hFFFF);
		rd(4'h3, 2'h1, 16'hBFFF, "p3 dir");
		acc(4'h5, 2'h1, 2'h3, 3'h1, 16'hFFFF);
		rd(4'h5, 2'h1, 16'h0000, "p5 dir");
		p5_in = 16'hC35A;
		step();
		rd(4'h5, 2'h0, 16'hC35A, "p5 pin");
		chk("p5 alt in", 16'hC35A, p5_alt_in);
		{seg_addr_en, seg_addr, input_threshold_select} = {1'b1, 8'hA7, 13'h1A5B};
		step();
		step();
		chk("p4 seg", 16'h00A7, {p4_oe_n, p4_out});
		chk("thresh", 16'h1A5B, {3'h0, pad_thresh_cmos});
		seg_addr_en = 1'b0;
		{p7_alt_en, p7_alt_out} = {8'h0F, 8'h05};
		step();
		step();
		chk("p7 pwm out", 16'h0005, {8'h00, p7_out});
		p7_alt_en = 8'h00;
		$display("t_misc done");
	endtask : t_misc

	task automatic results();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	initial begin
		repeat (2000) @(posedge mclk);
		n_errors++;
		$display("watchdog expired");
		results();
	end

	initial begin
		{rst, acc_wr, acc_rd, acc_rmw, seg_addr_en, seg_addr} = {1'b1, 12'h000};
		{acc_port, acc_kind, acc_be, acc_wdata, input_threshold_select, p5_in} = '0;
		acc_op = ppl_pkg::PPL_RMW_AND;
		{p0_alt_en, p0_alt_out, p0_hw_en, p0_hw_dir, p1_alt_en, p1_alt_out, p1_hw_en} = '0;
		{p1_hw_dir, p2_alt_en, p2_alt_out, p3_alt_en, p3_alt_out} = '0;
		{p4_alt_en, p4_alt_out, p6_alt_en, p6_alt_out, p7_alt_en, p7_alt_out} = '0;
		{p8_alt_en, p8_alt_out} = '0;
		for (int i = 0; i < 9; i++) begin
			{xv[i], xd[i]} = {16'h3C96, 16'hFFFF};
		end
		{n_errors, compares} = '0;
		repeat (5) @(posedge mclk);
		#1;
		rst = 1'b0;
		chk("oe_n after reset", 16'hFFFF, p2_oe_n);
		t_io();
		t_p0();
		t_misc();
		results();
	end
endmodule : ppl_top_tb
